/* File: include/swseq_pkg.sv */
package swseq_pkg;

  localparam int NUM_WAKE = 8;
  localparam int CNT_W    = 8;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_COUNT  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // Control bits
  localparam int CTRL_RET_BIT   = 0;
  localparam int CTRL_HS_BIT    = 1;
  localparam int CTRL_MULTI_BIT = 2;
  localparam int CTRL_DRIVE_BIT = 3;
  localparam int CTRL_GSR_BIT   = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // Wake mask, all pins enabled after reset
  localparam logic [7:0] MASK_RST = 8'hff;

  // Count fields
  localparam int CNT_OUT_LSB = 0;
  localparam int CNT_WR_LSB  = 8;
  localparam logic [7:0] OUT_REL_RST = 8'h04;
  localparam logic [7:0] WR_REL_RST  = 8'h05;

  // Status fields
  localparam int ST_STATE_LSB  = 0;
  localparam int ST_WREN_BIT   = 4;
  localparam int ST_OUTACT_BIT = 5;
  localparam int ST_BLOCK_BIT  = 6;
  localparam int ST_RUN_BIT    = 7;
  localparam int ST_REQ_BIT    = 8;

  typedef enum logic [3:0] {
    SWSEQ_RUNNING_INDICATOR   = 4'b0000,
    SWSEQ_REQ     = 4'b0001,
    SWSEQ_WPROT   = 4'b0010,
    SWSEQ_INDLOW  = 4'b0011,
    SWSEQ_OUTSLP  = 4'b0100,
    SWSEQ_BLOCK   = 4'b0101,
    SWSEQ_RETAIN  = 4'b0110,
    SWSEQ_UNBLOCK = 4'b0111,
    SWSEQ_INDHIGH = 4'b1000,
    SWSEQ_RELEASE = 4'b1001
  } swseq_state_t;

endpackage

/* File: design/swseq_wake_detect.sv */
`timescale 1ns/1ps
module swseq_wake_detect
  import swseq_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire logic                clkEn,
  input  wire logic                sleepReq,
  input  wire logic [NUM_WAKE-1:0] wakePin,
  input  wire logic [NUM_WAKE-1:0] wakeMask,
  input  wire logic                multiWake,
  output logic                     wakeGo
);

  logic [NUM_WAKE-1:0] hitVec;
  logic                wakeGo_r;

  // One enable gate per wake pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WAKE; gi++) begin : g_pin
      assign hitVec[gi] = wakePin[gi] & wakeMask[gi];
    end
  endgenerate

  // Level test: a pin already high when the request falls wakes at once
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wakeGo_r <= 1'b0;
    end else if (clkEn) begin
      if (multiWake) begin
        wakeGo_r <= !sleepReq && (|hitVec);
      end else begin
        wakeGo_r <= !sleepReq;
      end
    end
  end

  assign wakeGo = wakeGo_r;

  a_wake_combo: assert property (@(posedge mclk) disable iff (!nrst)
    (clkEn && multiWake && (sleepReq || ((wakePin & wakeMask) == 8'h00))) |=> !wakeGo)
    else $error("wake raised without request low and an enabled pin high");

  a_wake_plain: assert property (@(posedge mclk) disable iff (!nrst)
    (clkEn && !multiWake && !sleepReq) |=> wakeGo)
    else $error("wake not raised after request fell");

endmodule

/* File: design/swseq_top.sv */
`timescale 1ns/1ps
// How it works
// - No retention unless feature enabled
// - No handshake: enter at once on request
// - Handshake: raise entry request output
// - Handshake: wait for acknowledge before entry
// - Capture hold values, present at sleep switch
// - First step: drop global write enable
// - Then drive running indicator low
// - Then switch outputs to sleep behaviour
// - Last: block inputs, interconnect off
// - Configuration done stays high throughout
// - Up to eight selectable wake pins
// - Plain wake: request low starts exit
// - Multi wake: request low, then pin
// - Pin already high wakes immediately
// - Exit first unblocks inputs, writes protected
// - Drive indicator or release and wait high
// - Outputs release after count, default four
// - Writes release after count, default five
// - Write release should follow output release
// - Eight-bit wake mask, one bit each
// - Optional global set/reset on exit
module swseq_top
  import swseq_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          nrst,
  input  wire logic                          clkEn,
  input  wire logic [swseq_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [swseq_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [swseq_pkg::DATA_W-1:0]  regRdata,
  input  wire logic                          sleepReq,
  input  wire logic [swseq_pkg::NUM_WAKE-1:0] wakePin,
  input  wire logic                          runIndIn,
  output logic                               runIndOut,
  output logic                               runIndOe,
  output logic                               entryRequestOut,
  input  wire logic                          entryAckIn,
  input  wire logic [swseq_pkg::NUM_WAKE-1:0] userOutVal,
  output logic      [swseq_pkg::NUM_WAKE-1:0] heldOutVal,
  output logic                               sleepOutputs,
  output logic                               outputsActive,
  output logic                               writeEnable,
  output logic                               inputsBlocked,
  output logic                               globalSetReset,
  output logic                               configDone
);

  swseq_state_t        state_r;
  swseq_state_t        state_nxt;
  logic [4:0]          ctrl_r;
  logic [7:0]          wakeMask_r;
  logic [CNT_W-1:0]    outRel_r;
  logic [CNT_W-1:0]    wrRel_r;
  logic [CNT_W-1:0]    relCnt_r;
  logic [CNT_W-1:0]    relMax;
  logic [DATA_W-1:0]   regRdata_r;
  logic [DATA_W-1:0]   rdMux;
  logic [NUM_WAKE-1:0] capture_r;
  logic [NUM_WAKE-1:0] heldOut_r;
  logic                runOut_r;
  logic                runOe_r;
  logic                entryReq_r;
  logic                sleepOut_r;
  logic                outAct_r;
  logic                wrEn_r;
  logic                blocked_r;
  logic                gsr_r;
  logic                done_r;
  logic                wakeGo;
  logic                cfgRet;
  logic                cfgHs;
  logic                cfgMulti;
  logic                cfgDrive;
  logic                cfgGsr;
  logic                stepEnter;

  assign cfgRet   = ctrl_r[CTRL_RET_BIT];
  assign cfgHs    = ctrl_r[CTRL_HS_BIT];
  assign cfgMulti = ctrl_r[CTRL_MULTI_BIT];
  assign cfgDrive = ctrl_r[CTRL_DRIVE_BIT];
  assign cfgGsr   = ctrl_r[CTRL_GSR_BIT];
  assign relMax   = (wrRel_r > outRel_r) ? wrRel_r : outRel_r;
  assign stepEnter = clkEn && (state_nxt != state_r);

  swseq_wake_detect u_wake (
    .mclk      (mclk),
    .nrst      (nrst),
    .clkEn     (clkEn),
    .sleepReq  (sleepReq),
    .wakePin   (wakePin),
    .wakeMask  (wakeMask_r),
    .multiWake (cfgMulti),
    .wakeGo    (wakeGo)
  );

  // Configuration registers; the sequence reads them live, so software
  // should only change them while the block is running_indicator
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_r     <= CTRL_RST;
      wakeMask_r <= MASK_RST;
      outRel_r   <= OUT_REL_RST;
      wrRel_r    <= WR_REL_RST;
    end else if (clkEn && regWr) begin
      if (regAddr == REG_CTRL) begin
        ctrl_r <= regWdata[4:0];
      end else if (regAddr == REG_MASK) begin
        wakeMask_r <= regWdata[7:0];
      end else if (regAddr == REG_COUNT) begin
        outRel_r <= regWdata[CNT_OUT_LSB +: CNT_W];
        wrRel_r  <= regWdata[CNT_WR_LSB +: CNT_W];
      end
    end
  end

  always_comb begin
    rdMux = '0;
    if (regAddr == REG_CTRL) begin
      rdMux[4:0] = ctrl_r;
    end else if (regAddr == REG_MASK) begin
      rdMux[7:0] = wakeMask_r;
    end else if (regAddr == REG_COUNT) begin
      rdMux[CNT_OUT_LSB +: CNT_W] = outRel_r;
      rdMux[CNT_WR_LSB +: CNT_W]  = wrRel_r;
    end else if (regAddr == REG_STATUS) begin
      rdMux[ST_STATE_LSB +: 4] = state_r;
      rdMux[ST_WREN_BIT]       = wrEn_r;
      rdMux[ST_OUTACT_BIT]     = outAct_r;
      rdMux[ST_BLOCK_BIT]      = blocked_r;
      rdMux[ST_RUN_BIT]        = runIndIn;
      rdMux[ST_REQ_BIT]        = sleepReq;
    end
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      regRdata_r <= '0;
    end else if (clkEn) begin
      regRdata_r <= regRd ? rdMux : '0;
    end
  end

  // Step sequencer; each step is its own state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SWSEQ_RUNNING_INDICATOR: begin
        if (cfgRet && sleepReq) begin
          state_nxt = cfgHs ? SWSEQ_REQ : SWSEQ_WPROT;
        end
      end
      SWSEQ_REQ: begin
        // A withdrawn request aborts before anything was frozen
        if (!sleepReq) begin
          state_nxt = SWSEQ_RUNNING_INDICATOR;
        end else if (entryAckIn) begin
          state_nxt = SWSEQ_WPROT;
        end
      end
      SWSEQ_WPROT:   state_nxt = SWSEQ_INDLOW;
      SWSEQ_INDLOW:  state_nxt = SWSEQ_OUTSLP;
      SWSEQ_OUTSLP:  state_nxt = SWSEQ_BLOCK;
      SWSEQ_BLOCK:   state_nxt = SWSEQ_RETAIN;
      SWSEQ_RETAIN: begin
        if (wakeGo) begin
          state_nxt = SWSEQ_UNBLOCK;
        end
      end
      SWSEQ_UNBLOCK: state_nxt = SWSEQ_INDHIGH;
      SWSEQ_INDHIGH: begin
        if (cfgDrive || runIndIn) begin
          state_nxt = SWSEQ_RELEASE;
        end
      end
      SWSEQ_RELEASE: begin
        if (relCnt_r >= relMax) begin
          state_nxt = SWSEQ_RUNNING_INDICATOR;
        end
      end
      default: state_nxt = SWSEQ_RUNNING_INDICATOR;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r <= SWSEQ_RUNNING_INDICATOR;
    end else if (clkEn) begin
      state_r <= state_nxt;
    end
  end

  // Release timer counts cycles since the indicator read high
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      relCnt_r <= '0;
    end else if (clkEn) begin
      if (state_r == SWSEQ_INDHIGH && state_nxt == SWSEQ_RELEASE) begin
        relCnt_r <= 8'h01;
      end else if (state_r == SWSEQ_RELEASE && relCnt_r != 8'hff) begin
        relCnt_r <= relCnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      entryReq_r <= 1'b0;
    end else if (clkEn) begin
      entryReq_r <= (state_nxt == SWSEQ_REQ);
    end
  end

  // Hold values are caught as entry starts but shown only later
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      capture_r <= '0;
      heldOut_r <= '0;
    end else if (stepEnter) begin
      if (state_nxt == SWSEQ_WPROT) begin
        capture_r <= userOutVal;
      end
      if (state_nxt == SWSEQ_OUTSLP) begin
        heldOut_r <= capture_r;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wrEn_r <= 1'b1;
    end else if (clkEn) begin
      if (state_nxt == SWSEQ_WPROT) begin
        wrEn_r <= 1'b0;
      end else if (state_r == SWSEQ_RELEASE && relCnt_r >= wrRel_r) begin
        wrEn_r <= 1'b1;
      end
    end
  end

  // Released indicator relies on the external pull-up while running_indicator
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      runOut_r <= 1'b1;
      runOe_r  <= 1'b0;
    end else if (clkEn) begin
      if (state_nxt == SWSEQ_INDLOW && stepEnter) begin
        runOut_r <= 1'b0;
        runOe_r  <= 1'b1;
      end else if (state_nxt == SWSEQ_INDHIGH && stepEnter) begin
        runOut_r <= 1'b1;
        runOe_r  <= cfgDrive;
      end else if (state_r == SWSEQ_RUNNING_INDICATOR) begin
        runOut_r <= 1'b1;
        runOe_r  <= cfgDrive;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sleepOut_r <= 1'b0;
      outAct_r   <= 1'b1;
    end else if (clkEn) begin
      if (state_nxt == SWSEQ_OUTSLP && stepEnter) begin
        sleepOut_r <= 1'b1;
        outAct_r   <= 1'b0;
      end else if (state_r == SWSEQ_RELEASE && relCnt_r >= outRel_r) begin
        sleepOut_r <= 1'b0;
        outAct_r   <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      blocked_r <= 1'b0;
    end else if (stepEnter) begin
      if (state_nxt == SWSEQ_BLOCK) begin
        blocked_r <= 1'b1;
      end else if (state_nxt == SWSEQ_UNBLOCK) begin
        blocked_r <= 1'b0;
      end
    end
  end

  // Flip-flops keep their pre-entry state unless the option is set
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      gsr_r <= 1'b0;
    end else if (clkEn) begin
      gsr_r <= cfgGsr && (state_r == SWSEQ_RELEASE) && (state_nxt == SWSEQ_RUNNING_INDICATOR);
    end
  end

  // Configuration is never lost in retention
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      done_r <= 1'b1;
    end else if (clkEn) begin
      done_r <= 1'b1;
    end
  end

  assign regRdata        = regRdata_r;
  assign runIndOut       = runOut_r;
  assign runIndOe        = runOe_r;
  assign entryRequestOut = entryReq_r;
  assign heldOutVal      = heldOut_r;
  assign sleepOutputs    = sleepOut_r;
  assign outputsActive   = outAct_r;
  assign writeEnable     = wrEn_r;
  assign inputsBlocked   = blocked_r;
  assign globalSetReset  = gsr_r;
  assign configDone      = done_r;

  a_retention_gate: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r == SWSEQ_RUNNING_INDICATOR && !cfgRet) |=> state_r == SWSEQ_RUNNING_INDICATOR)
    else $error("entry began with retention disabled");

  a_direct_entry: assert property (@(posedge mclk) disable iff (!nrst)
    (clkEn && state_r == SWSEQ_RUNNING_INDICATOR && cfgRet && !cfgHs && sleepReq)
    |=> (state_r == SWSEQ_WPROT && !writeEnable))
    else $error("direct entry did not start");

  a_request_raise: assert property (@(posedge mclk) disable iff (!nrst)
    (clkEn && state_r == SWSEQ_RUNNING_INDICATOR && cfgRet && cfgHs && sleepReq)
    |=> (entryRequestOut && state_r == SWSEQ_REQ))
    else $error("entry request not raised");

  a_ack_wait: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r == SWSEQ_REQ && !entryAckIn) |=> (writeEnable && state_r != SWSEQ_WPROT))
    else $error("entry went ahead without acknowledge");

  a_write_held: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r inside {SWSEQ_WPROT, SWSEQ_INDLOW, SWSEQ_OUTSLP, SWSEQ_BLOCK,
                     SWSEQ_RETAIN, SWSEQ_UNBLOCK, SWSEQ_INDHIGH}) |-> !writeEnable)
    else $error("writes enabled during retention");

  a_ind_low: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r inside {SWSEQ_INDLOW, SWSEQ_OUTSLP, SWSEQ_BLOCK, SWSEQ_RETAIN,
                     SWSEQ_UNBLOCK}) |-> (runIndOe && !runIndOut))
    else $error("running indicator not low while retained");

  a_entry_order: assert property (@(posedge mclk) disable iff (!nrst)
    (clkEn && state_r == SWSEQ_INDLOW)
    |=> ((sleepOutputs && !outputsActive) and (clkEn |=> inputsBlocked)))
    else $error("entry steps out of order");

  a_hold_value: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(sleepOutputs) |-> heldOutVal == $past(capture_r))
    else $error("held value does not match capture");

  a_unblock_first: assert property (@(posedge mclk) disable iff (!nrst)
    (clkEn && state_r == SWSEQ_RETAIN && wakeGo) |=> (!inputsBlocked && !writeEnable))
    else $error("inputs not released first on exit");

  a_out_release: assert property (@(posedge mclk) disable iff (!nrst)
    (clkEn && state_r == SWSEQ_RELEASE && relCnt_r >= outRel_r) |=> outputsActive)
    else $error("outputs not released at count");

  a_done_high: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r == SWSEQ_RETAIN) |-> configDone)
    else $error("configuration done dropped in retention");

endmodule

/* File: verification/swseq_partner.sv */
`timescale 1ns/1ps
module swseq_partner (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       runIndOut,
  input  wire logic       runIndOe,
  input  wire logic       entryRequestOut,
  input  wire logic [7:0] pullDelay,
  input  wire logic [7:0] ackDelay,
  output logic            runIndIn,
  output logic            entryAckIn
);
  logic [7:0] relCnt_r;
  logic [7:0] ackCnt_r;

  // Another board device holds the released line low until it is ready
  always_ff @(posedge mclk) begin
    if (!nrst || runIndOe) begin
      relCnt_r <= 8'h00;
    end else if (relCnt_r != 8'hff) begin
      relCnt_r <= relCnt_r + 8'h01;
    end
  end
  assign runIndIn = runIndOe ? runIndOut : (relCnt_r >= pullDelay);

  // Pending application work takes ackDelay cycles
  always_ff @(posedge mclk) begin
    if (!nrst || !entryRequestOut) begin
      ackCnt_r <= 8'h00;
    end else if (ackCnt_r != 8'hff) begin
      ackCnt_r <= ackCnt_r + 8'h01;
    end
  end
  assign entryAckIn = entryRequestOut && (ackCnt_r >= ackDelay);
endmodule

/* File: verification/tb_swseq_top.sv */
`timescale 1ns/1ps
module tb_swseq_top;
  import swseq_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst, clkEn, regWr, regRd, sleepReq;
  logic [7:0]  regAddr, wakePin, userOutVal, heldOutVal, pullDelay, ackDelay;
  logic [31:0] regWdata, regRdata, rd;
  logic        runIndIn, runIndOut, runIndOe, entryRequestOut, entryAckIn;
  logic        sleepOutputs, outputsActive, writeEnable, inputsBlocked;
  logic        globalSetReset, configDone;
  int          mismatches = 0;
  int          comparisons = 0;
  int          n;

  swseq_top dut (.mclk(mclk), .nrst(nrst), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .sleepReq(sleepReq), .wakePin(wakePin), .runIndIn(runIndIn), .runIndOut(runIndOut),
    .runIndOe(runIndOe), .entryRequestOut(entryRequestOut), .entryAckIn(entryAckIn),
    .userOutVal(userOutVal), .heldOutVal(heldOutVal), .sleepOutputs(sleepOutputs),
    .outputsActive(outputsActive), .writeEnable(writeEnable), .inputsBlocked(inputsBlocked),
    .globalSetReset(globalSetReset), .configDone(configDone));

  swseq_partner partner (.mclk(mclk), .nrst(nrst), .runIndOut(runIndOut),
    .runIndOe(runIndOe), .entryRequestOut(entryRequestOut), .pullDelay(pullDelay),
    .ackDelay(ackDelay), .runIndIn(runIndIn), .entryAckIn(entryAckIn));

  always #12.5 mclk = ~mclk;

  // Sample a little after the edge so the edge's updates have landed
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // Bounded wait; cnt is the number of edges until the condition held
  task automatic waitFor(input int which, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit) begin
      tick;
      cnt++;
      case (which)
        0: hit = (runIndIn === 1'b1);
        1: hit = (inputsBlocked === 1'b0);
        2: hit = (writeEnable === 1'b0);
        3: hit = (inputsBlocked === 1'b1);
        default: hit = (entryRequestOut === 1'b1);
      endcase
      if (!hit && cnt >= 500) begin
        mismatches++;
        $display("[FAIL] wait %0d expected done seen timeout", which);
        end_sim;
      end
    end
  endtask

  // Called at the cycle where the indicator first reads high
  task automatic measureRelease(input int expOut, input int expWr, input int expGsr);
    int tOut;
    int tWr;
    int gsr;
    logic [31:0] st;
    tOut = 0;
    tWr = 0;
    gsr = 0;
    for (int i = 1; i <= 40; i++) begin
      tick;
      if (outputsActive === 1'b1 && tOut == 0) tOut = i;
      if (writeEnable === 1'b1 && tWr == 0) tWr = i;
      if (globalSetReset === 1'b1) gsr++;
    end
    check("output release cycle", tOut, expOut);
    check("write release cycle", tWr, expWr);
    check("set reset pulses", gsr, expGsr);
    regRead(REG_STATUS, st);
    check("state after exit", st[3:0], 4'h0);
  endtask

  initial begin
    nrst = 1'b0;
    clkEn = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    sleepReq = 1'b0;
    wakePin = 8'h00;
    userOutVal = 8'ha5;
    pullDelay = 8'h00;
    ackDelay = 8'h04;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    tick;
    check("idle outputs", {writeEnable, outputsActive, inputsBlocked, sleepOutputs,
      configDone, runIndOe, entryRequestOut}, 7'b1100100);
    regRead(REG_CTRL, rd);
    check("ctrl reset", rd, 32'h0);
    regRead(REG_MASK, rd);
    check("mask reset", rd, 32'hff);
    regRead(REG_COUNT, rd);
    check("count reset", rd, 32'h0504);
    regRead(REG_STATUS, rd);
    check("status reset", rd, 32'hb0);
    regRead(8'h20, rd);
    check("unmapped read", rd, 32'h0);
    tick;
    check("read data after", regRdata, 32'h0);
    // A write strobe while the enable is low must be dropped
    @(posedge mclk);
    clkEn <= 1'b0;
    regWrite(REG_MASK, 32'h00);
    clkEn <= 1'b1;
    regRead(REG_MASK, rd);
    check("write while frozen", rd, 32'hff);
    $display("test reset done");

    @(posedge mclk);
    sleepReq <= 1'b1;
    repeat (6) tick;
    check("feature off outputs", {writeEnable, inputsBlocked, runIndOe}, 3'b100);
    regRead(REG_STATUS, rd);
    check("feature off status", rd, 32'h1b0);
    @(posedge mclk);
    sleepReq <= 1'b0;
    $display("test feature off done");

    regWrite(REG_CTRL, 32'h09);
    @(posedge mclk);
    sleepReq <= 1'b1;
    tick;
    check("write protect first", {writeEnable, runIndOut}, 2'b01);
    @(posedge mclk);
    userOutVal <= 8'h3c;
    #1;
    check("indicator low", {runIndOut, runIndOe, sleepOutputs}, 3'b010);
    tick;
    check("sleep outputs", {sleepOutputs, outputsActive, inputsBlocked}, 3'b100);
    check("held value", heldOutVal, 8'ha5);
    tick;
    check("blocked", {inputsBlocked, configDone}, 2'b11);
    regRead(REG_STATUS, rd);
    check("retention status", rd, 32'h146);
    @(posedge mclk);
    sleepReq <= 1'b0;
    tick;
    tick;
    check("inputs freed first", {inputsBlocked, writeEnable, runIndOut}, 3'b000);
    tick;
    check("indicator driven", {runIndOut, runIndOe, configDone}, 3'b111);
    measureRelease(5, 6, 0);
    $display("test plain cycle done");

    regWrite(REG_MASK, 32'h0f);
    regRead(REG_MASK, rd);
    check("mask write", rd, 32'h0f);
    regWrite(REG_COUNT, 32'h0302);
    regRead(REG_COUNT, rd);
    check("count write", rd, 32'h0302);
    regWrite(REG_CTRL, 32'h17);
    @(posedge mclk);
    pullDelay <= 8'h06;
    sleepReq <= 1'b1;
    waitFor(4, n);
    check("request delay", n, 1);
    check("no freeze before ack", writeEnable, 1'b1);
    waitFor(2, n);
    check("ack to freeze", n, 5);
    check("request dropped", entryRequestOut, 1'b0);
    waitFor(3, n);
    check("entry steps", n, 3);
    @(posedge mclk);
    sleepReq <= 1'b0;
    wakePin <= 8'h10;
    repeat (6) tick;
    check("masked pin ignored", inputsBlocked, 1'b1);
    @(posedge mclk);
    wakePin <= 8'h01;
    waitFor(1, n);
    check("pin wake delay", n, 2);
    tick;
    check("indicator released", {runIndOe, runIndIn, outputsActive}, 3'b000);
    waitFor(0, n);
    measureRelease(3, 4, 1);
    $display("test handshake cycle done");

    regWrite(REG_CTRL, 32'h0d);
    @(posedge mclk);
    sleepReq <= 1'b1;
    wakePin <= 8'h08;
    waitFor(3, n);
    repeat (3) tick;
    check("pin with request high", inputsBlocked, 1'b1);
    @(posedge mclk);
    sleepReq <= 1'b0;
    waitFor(1, n);
    check("pin already high", n, 2);
    waitFor(0, n);
    measureRelease(3, 4, 0);
    $display("test early pin done");
    end_sim;
  end
endmodule
